// ===== smpb_bank.sv
// smpb_bank.sv: second-motor parameter bank, an AXI4-Lite slave that
// keeps range-checked drive settings and the rated power lookup.
// assumes one clock, synchronous reset and a master that keeps to AXI4-Lite.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module smpb_bank
    import smpb_pkg::*;
#(
    parameter int ADDR_W = 16
)(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic [31:0]       startFreq,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              wvalid,
    output logic                   wready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    output logic                   bvalid,
    input  wire logic              bready,
    output logic [1:0]             bresp,
    input  wire logic              arvalid,
    output logic                   arready,
    input  wire logic [ADDR_W-1:0] araddr,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output smpb_param_t            params,
    output logic [15:0]            ratedPower
);

    // index bits must not alias the map
    if (ADDR_W < 16 || ADDR_W > 18)
    begin : g_addr_check
        $error("smpb_bank: ADDR_W must lie in 16..18");
    end

    // index to slot; anything not listed is reserved
    function automatic smpb_dec_t decode(input logic [15:0] idx);
        smpb_dec_t d;
        d = '{valid: 1'b1, pair: 1'b1, hi: 1'b0, ro: 1'b0, slot: S_ACC1};
        unique case (idx)
            IX_ACC1_HI: d.hi = 1'b1;
            IX_ACC1_LO: d.slot = S_ACC1;
            IX_DEC1_HI: d = '{1'b1, 1'b1, 1'b1, 1'b0, S_DEC1};
            IX_DEC1_LO: d.slot = S_DEC1;
            IX_BASE:    d = '{1'b1, 1'b0, 1'b0, 1'b0, S_BASE};
            IX_MAXF:    d = '{1'b1, 1'b0, 1'b0, 1'b0, S_MAXF};
            IX_MSPD_HI: d = '{1'b1, 1'b1, 1'b1, 1'b0, S_MSPD};
            IX_MSPD_LO: d.slot = S_MSPD;
            IX_BMETH:   d = '{1'b1, 1'b0, 1'b0, 1'b0, S_BMETH};
            IX_BVAL:    d = '{1'b1, 1'b0, 1'b0, 1'b0, S_BVAL};
            IX_BKNEE:   d = '{1'b1, 1'b0, 1'b0, 1'b0, S_BKNEE};
            IX_CURVE:   d = '{1'b1, 1'b0, 1'b0, 1'b0, S_CURVE};
            IX_VGAIN:   d = '{1'b1, 1'b0, 1'b0, 1'b0, S_VGAIN};
            IX_SGAIN:   d = '{1'b1, 1'b0, 1'b0, 1'b0, S_SGAIN};
            IX_UPL_HI:  d = '{1'b1, 1'b1, 1'b1, 1'b0, S_UPL};
            IX_UPL_LO:  d.slot = S_UPL;
            IX_LOL_HI:  d = '{1'b1, 1'b1, 1'b1, 1'b0, S_LOL};
            IX_LOL_LO:  d.slot = S_LOL;
            IX_ACC2_HI: d = '{1'b1, 1'b1, 1'b1, 1'b0, S_ACC2};
            IX_ACC2_LO: d.slot = S_ACC2;
            IX_DEC2_HI: d = '{1'b1, 1'b1, 1'b1, 1'b0, S_DEC2};
            IX_DEC2_LO: d.slot = S_DEC2;
            IX_RSW:     d = '{1'b1, 1'b0, 1'b0, 1'b0, S_RSW};
            IX_ATRN_HI: d = '{1'b1, 1'b1, 1'b1, 1'b0, S_ATRN};
            IX_ATRN_LO: d.slot = S_ATRN;
            IX_DTRN_HI: d = '{1'b1, 1'b1, 1'b1, 1'b0, S_DTRN};
            IX_DTRN_LO: d.slot = S_DTRN;
            IX_REGION:  d = '{1'b1, 1'b0, 1'b0, 1'b0, S_REGION};
            IX_CAP:     d = '{1'b1, 1'b0, 1'b0, 1'b0, S_CAP};
            IX_RATED:   d = '{1'b1, 1'b0, 1'b0, 1'b1, S_RATED};
            default:    d = '{1'b0, 1'b0, 1'b0, 1'b0, S_ACC1};
        endcase
        return d;
    endfunction

    // rated power in 0.01 kW; zero marks a code unused in that mode
    function automatic logic [15:0] capTable(
        input logic [15:0] mode,
        input logic [15:0] code
    );
        logic eu;
        logic [15:0] p;
        eu = (mode == REGION_EU);
        p = 16'h0000;
        unique case (code)
            16'd0:  p = 16'd20;
            16'd1:  p = eu ? 16'd37 : 16'h0000;
            16'd2:  p = eu ? 16'h0000 : 16'd40;
            16'd3:  p = eu ? 16'd55 : 16'h0000;
            16'd4:  p = 16'd75;
            16'd5:  p = eu ? 16'd110 : 16'h0000;
            16'd6:  p = 16'd150;
            16'd7:  p = 16'd220;
            16'd8:  p = eu ? 16'd300 : 16'h0000;
            16'd9:  p = eu ? 16'h0000 : 16'd370;
            16'd10: p = eu ? 16'd400 : 16'h0000;
            16'd11: p = 16'd550;
            16'd12: p = 16'd750;
            16'd13: p = 16'd1100;
            16'd14: p = 16'd1500;
            16'd15: p = 16'd1850;
            16'd16: p = 16'd2200;
            16'd17: p = 16'd3000;
            16'd18: p = 16'd3700;
            16'd19: p = 16'd4500;
            16'd20: p = 16'd5500;
            16'd21: p = 16'd7500;
            16'd22: p = 16'd9000;
            16'd23: p = 16'd11000;
            16'd24: p = 16'd13200;
            16'd25: p = 16'd15000;
            16'd26: p = 16'd16000;
            default: p = 16'h0000;
        endcase
        return p;
    endfunction

    logic [31:0]       store [NSTORE];
    logic [15:0]       stageHi;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              inRange;

    // write decode and candidate value
    wire smpb_dec_t   wrDec   = decode(16'(awAddr[ADDR_W-1:2]));
    wire logic [15:0] lo16    = wData[15:0];
    wire logic [31:0] val32   = wrDec.pair ? {stageHi, lo16}
                                           : {16'h0000, lo16};
    wire logic [15:0] maxHz   = store[S_MAXF][15:0];
    wire logic [31:0] maxCent = 32'(maxHz) * HZ_SCALE;
    wire logic [31:0] lowLim  = store[S_LOL];
    wire logic [15:0] region  = store[S_REGION][15:0];
    wire logic        wrFire  = ce && !awready && !wready && !bvalid;
    wire logic        wrOk    = wrDec.valid && !wrDec.ro
                                && (wStrb[1:0] == 2'h3)
                                && (wrDec.hi || inRange);
    wire logic        wrStore = wrFire && wrOk && !wrDec.hi
                                && (wrDec.slot != S_RATED);
    wire logic [31:0] wrWord  = (wrDec.slot < S_RATED)
                                ? store[wrDec.slot] : 32'h0000_0000;

    // accepted range of the value being written
    always_comb
    begin
        inRange = 1'b0;
        unique case (wrDec.slot)
            S_ACC1, S_DEC1, S_ACC2, S_DEC2:
                inRange = (val32 >= TIME_MIN) && (val32 <= TIME_MAX);
            S_BASE:
                inRange = (lo16 >= FREQ_MIN_HZ) && (lo16 <= maxHz);
            S_MAXF:
                inRange = (lo16 >= FREQ_MIN_HZ)
                          && (lo16 <= FREQ_MAX_HZ);
            S_MSPD, S_LOL:
                inRange = (val32 == 32'h0)
                          || ((val32 >= startFreq) && (val32 <= maxCent));
            S_UPL:
                inRange = (val32 == 32'h0)
                          || ((val32 >= lowLim) && (val32 <= maxCent));
            S_BMETH:  inRange = (lo16 <= METH_MAX);
            S_BVAL:   inRange = (lo16 <= BOOST_MAX);
            S_BKNEE:  inRange = (lo16 <= KNEE_MAX);
            S_CURVE:  inRange = (lo16 <= CURVE_MAX);
            S_VGAIN, S_SGAIN: inRange = (lo16 <= GAIN_MAX);
            S_RSW:    inRange = (lo16 <= RSW_MAX);
            S_ATRN, S_DTRN: inRange = (val32 <= TRN_MAX);
            S_REGION: inRange = (lo16 <= REGION_MAX);
            S_CAP:    inRange = (lo16 <= CAP_MAX)
                                && (capTable(region, lo16) != 16'h0);
            default:  inRange = 1'b0;
        endcase
    end

    // write channels: take address and data in either order, then answer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            awAddr  <= '0;
            wData   <= 32'h0;
            wStrb   <= 4'h0;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                awAddr  <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready)
            begin
                wData  <= wdata;
                wStrb  <= wstrb;
                wready <= 1'b0;
            end
            if (wrFire)
            begin
                bvalid <= 1'b1;
                bresp  <= wrOk ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // settings storage; the high word of a pair waits for its low word
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < NSTORE; i++)
                store[i] <= RST_STORE[i];
            stageHi <= 16'h0000;
        end
        else
        begin
            if (wrFire && wrOk && wrDec.hi)
                stageHi <= lo16;
            if (wrStore)
                store[wrDec.slot] <= val32;
        end
    end

    // rated power follows the stored mode and code
    always_ff @(posedge clk)
    begin
        if (rst)
            ratedPower <= 16'h0000;
        else if (ce)
            ratedPower <= capTable(region, store[S_CAP][15:0]);
    end

    // read decode and data selection
    wire smpb_dec_t   rdDec  = decode(16'(araddr[ADDR_W-1:2]));
    wire logic [31:0] rdWord = (rdDec.slot < S_RATED)
                               ? store[rdDec.slot] : 32'h0000_0000;
    wire logic [31:0] rdHalf = rdDec.hi ? {16'h0000, rdWord[31:16]}
                                        : {16'h0000, rdWord[15:0]};
    wire logic [31:0] rdVal  = !rdDec.valid ? 32'h0000_0000
                             : (rdDec.slot == S_RATED)
                               ? {16'h0000, ratedPower}
                             : rdDec.pair ? rdHalf : rdWord;

    // read channel: one read at a time, data one edge after the address
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rdVal;
                rresp   <= rdDec.valid ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid && rready)
            begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // settings presented to the drive logic
    assign params.firstAccelTime        = store[S_ACC1];
    assign params.firstDecelTime        = store[S_DEC1];
    assign params.baseFrequency         = store[S_BASE][15:0];
    assign params.maximumFrequency      = maxHz;
    assign params.multispeedFrequency   = store[S_MSPD];
    assign params.boostMethod           = store[S_BMETH][15:0];
    assign params.manualBoostAmount     = store[S_BVAL][15:0];
    assign params.manualBoostKnee       = store[S_BKNEE][15:0];
    assign params.curveSelection        = store[S_CURVE][15:0];
    assign params.autoBoostVoltGain     = store[S_VGAIN][15:0];
    assign params.autoBoostSlipGain     = store[S_SGAIN][15:0];
    assign params.upperFreqLimit        = store[S_UPL];
    assign params.lowerFreqLimit        = lowLim;
    assign params.secondAccelTime       = store[S_ACC2];
    assign params.secondDecelTime       = store[S_DEC2];
    assign params.rampStageSwitchMethod = store[S_RSW][15:0];
    assign params.accelStageChangeFreq  = store[S_ATRN];
    assign params.decelStageChangeFreq  = store[S_DTRN];
    assign params.regionalModeSelect    = region;
    assign params.motorCapacityCode     = store[S_CAP][15:0];
    // helper copy of the slot a write aimed at
    logic [4:0]  lastSlot;
    logic [31:0] lastVal;
    always_ff @(posedge clk)
    begin
        lastSlot <= wrDec.slot;
        lastVal  <= wrWord;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // checks on stored values and bus answers
    a_reject_keeps:
        assert property (wrFire && !wrOk && !wrDec.hi
                         |=> (lastSlot >= 5'(NSTORE))
                             || (store[lastSlot] == lastVal))
        else $error("rejected write changed a stored value");
    a_unmapped_write:
        assert property (wrFire && !wrDec.valid
                         |=> bvalid && (bresp == RESP_SLVERR))
        else $error("reserved write not refused");
    a_unmapped_read:
        assert property (ce && arvalid && arready && !rdDec.valid
                         |=> rvalid && (rresp == RESP_SLVERR)
                             && (rdata == 32'h0))
        else $error("reserved read not refused");
    a_first_times:
        assert property (##1 (store[S_ACC1] >= TIME_MIN)
                         && (store[S_ACC1] <= TIME_MAX)
                         && (store[S_DEC1] >= TIME_MIN)
                         && (store[S_DEC1] <= TIME_MAX))
        else $error("first ramp time out of range");
    a_second_times:
        assert property (##1 (store[S_ACC2] >= TIME_MIN)
                         && (store[S_ACC2] <= TIME_MAX)
                         && (store[S_DEC2] >= TIME_MIN)
                         && (store[S_DEC2] <= TIME_MAX))
        else $error("second ramp time out of range");
    a_max_range:
        assert property (##1 (maxHz >= FREQ_MIN_HZ)
                         && (maxHz <= FREQ_MAX_HZ))
        else $error("maximum frequency out of range");
    a_base_write:
        assert property (wrFire && (wrDec.slot == S_BASE)
                         && (lo16 > maxHz)
                         |=> $stable(params.baseFrequency))
        else $error("base frequency above maximum taken");
    a_limit_write:
        assert property (wrStore && ((wrDec.slot == S_UPL)
                         || (wrDec.slot == S_LOL)
                         || (wrDec.slot == S_MSPD))
                         |=> (store[lastSlot] == 32'h0)
                             || (store[lastSlot] <= maxCent))
        else $error("frequency limit above maximum taken");
    a_code_fields:
        assert property (##1 (params.boostMethod <= METH_MAX)
                         && (params.curveSelection <= CURVE_MAX)
                         && (params.rampStageSwitchMethod <= RSW_MAX))
        else $error("selection code out of range");
    a_boost_range:
        assert property (##1 (params.manualBoostAmount <= BOOST_MAX)
                         && (params.manualBoostKnee <= KNEE_MAX))
        else $error("manual boost out of range");
    a_stage_freq:
        assert property (##1 (store[S_ATRN] <= TRN_MAX)
                         && (store[S_DTRN] <= TRN_MAX))
        else $error("stage change frequency out of range");
    a_rated_follow:
        assert property (wrStore && (wrDec.slot == S_CAP) ##1 ce
                         |=> (ratedPower != 16'h0000))
        else $error("accepted capacity code gives no rating");

endmodule // smpb_bank

`default_nettype wire

// ===== smpb_pkg.sv
// smpb_pkg.sv: indices, storage slots, limits and carrier types of the
// second-motor parameter bank.
// assumes an AXI4-Lite master; a byte address is four times the index.
package smpb_pkg;

    // register indices; byte address = index * 4
    localparam logic [15:0] IX_ACC1_HI = 16'h2103, IX_ACC1_LO = 16'h2104,
        IX_DEC1_HI = 16'h2105, IX_DEC1_LO = 16'h2106,
        IX_BASE    = 16'h2203, IX_MAXF    = 16'h2204,
        IX_MSPD_HI = 16'h2216, IX_MSPD_LO = 16'h2217,
        IX_BMETH   = 16'h223b, IX_BVAL    = 16'h223c,
        IX_BKNEE   = 16'h223d, IX_CURVE   = 16'h223e,
        IX_VGAIN   = 16'h2240, IX_SGAIN   = 16'h2241,
        IX_UPL_HI  = 16'h224f, IX_UPL_LO  = 16'h2250,
        IX_LOL_HI  = 16'h2251, IX_LOL_LO  = 16'h2252,
        IX_ACC2_HI = 16'h226f, IX_ACC2_LO = 16'h2270,
        IX_DEC2_HI = 16'h2271, IX_DEC2_LO = 16'h2272,
        IX_RSW     = 16'h2273,
        IX_ATRN_HI = 16'h2274, IX_ATRN_LO = 16'h2275,
        IX_DTRN_HI = 16'h2276, IX_DTRN_LO = 16'h2277,
        IX_REGION  = 16'h2600, IX_CAP     = 16'h2601,
        IX_RATED   = 16'h2602;

    // storage slots; a split pair shares one 32-bit slot
    typedef enum logic [4:0] {
        S_ACC1 = 5'h00, S_DEC1 = 5'h01, S_BASE = 5'h02, S_MAXF = 5'h03,
        S_MSPD = 5'h04, S_BMETH = 5'h05, S_BVAL = 5'h06, S_BKNEE = 5'h07,
        S_CURVE = 5'h08, S_VGAIN = 5'h09, S_SGAIN = 5'h0a, S_UPL = 5'h0b,
        S_LOL = 5'h0c, S_ACC2 = 5'h0d, S_DEC2 = 5'h0e, S_RSW = 5'h0f,
        S_ATRN = 5'h10, S_DTRN = 5'h11, S_REGION = 5'h12, S_CAP = 5'h13,
        S_RATED = 5'h14
    } smpb_slot_t;
    localparam int NSTORE = 20;

    // accepted ranges
    localparam logic [31:0] TIME_MIN = 32'h0000_0001;
    localparam logic [31:0] TIME_MAX = 32'h0005_7e40;
    localparam logic [31:0] TRN_MAX  = 32'h0000_9c40;
    localparam logic [31:0] HZ_SCALE = 32'h0000_0064;
    localparam logic [15:0] FREQ_MIN_HZ = 16'h001e;
    localparam logic [15:0] FREQ_MAX_HZ = 16'h0190;
    localparam logic [15:0] METH_MAX   = 16'h0001;
    localparam logic [15:0] BOOST_MAX  = 16'h00c8;
    localparam logic [15:0] KNEE_MAX   = 16'h01f4;
    localparam logic [15:0] CURVE_MAX  = 16'h0004;
    localparam logic [15:0] GAIN_MAX   = 16'h00ff;
    localparam logic [15:0] RSW_MAX    = 16'h0002;
    localparam logic [15:0] REGION_MAX = 16'h0002;
    localparam logic [15:0] REGION_EU  = 16'h0001;
    localparam logic [15:0] CAP_MAX    = 16'h001a;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // reset contents of every slot, in slot order
    localparam logic [31:0] RST_STORE [NSTORE] = '{
        32'h0000_0bb8, 32'h0000_0bb8, 32'h0000_003c, 32'h0000_003c,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0bb8, 32'h0000_0bb8, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0004
    };

    // result of decoding one register index
    typedef struct packed {
        logic       valid;
        logic       pair;
        logic       hi;
        logic       ro;
        smpb_slot_t slot;
    } smpb_dec_t;

    // stored settings as seen by the drive logic
    typedef struct packed {
        logic [31:0] firstAccelTime;
        logic [31:0] firstDecelTime;
        logic [15:0] baseFrequency;
        logic [15:0] maximumFrequency;
        logic [31:0] multispeedFrequency;
        logic [15:0] boostMethod;
        logic [15:0] manualBoostAmount;
        logic [15:0] manualBoostKnee;
        logic [15:0] curveSelection;
        logic [15:0] autoBoostVoltGain;
        logic [15:0] autoBoostSlipGain;
        logic [31:0] upperFreqLimit;
        logic [31:0] lowerFreqLimit;
        logic [31:0] secondAccelTime;
        logic [31:0] secondDecelTime;
        logic [15:0] rampStageSwitchMethod;
        logic [31:0] accelStageChangeFreq;
        logic [31:0] decelStageChangeFreq;
        logic [15:0] regionalModeSelect;
        logic [15:0] motorCapacityCode;
    } smpb_param_t;

endpackage

// ===== smpb_host.sv
// smpb_host.sv: AXI4-Lite master model acting as the host.
// assumes the bank answers each channel in its own time.
`timescale 1ns/1ps
`default_nettype none
module smpb_host (
    input  wire logic        clk,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [15:0]      awaddr,
    output logic             wvalid,
    input  wire logic        wready,
    output logic [31:0]      wdata,
    input  wire logic        bvalid,
    output logic             bready,
    input  wire logic [1:0]  bresp,
    output logic             arvalid,
    input  wire logic        arready,
    output logic [15:0]      araddr,
    input  wire logic        rvalid,
    output logic             rready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp
);
    // idle bus; answers are always accepted at once
    initial
    begin
        {awvalid, wvalid, arvalid} = 3'h0;
        {bready, rready} = 2'h3;
        {awaddr, araddr, wdata} = 64'h0;
    end

    // one write: address and data together, each released when taken
    task automatic wr(logic [15:0] ix, logic [15:0] d,
                      output logic [1:0] r);
        logic a;
        logic w;
        a = 1'b1;
        w = 1'b1;
        awaddr <= {ix[13:0], 2'h0};
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (a || w)
        begin
            @(posedge clk);
            a = a && !awready;
            w = w && !wready;
            awvalid <= a;
            wvalid <= w;
        end
        do
            @(posedge clk);
        while (!bvalid);
        r = bresp;
    endtask

    // one read: address held until taken, data taken with rvalid
    task automatic rd(logic [15:0] ix, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= {ix[13:0], 2'h0};
        arvalid <= 1'b1;
        do
            @(posedge clk);
        while (!arready);
        arvalid <= 1'b0;
        do
            @(posedge clk);
        while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
endmodule // smpb_host
`default_nettype wire

// ===== smpb_bank_tb_top.sv
// smpb_bank_tb_top.sv: self-checking bench for the parameter bank.
// assumes smpb_host drives the register bus.
`timescale 1ns/1ps
`default_nettype none
module smpb_bank_tb_top
    import smpb_pkg::*;
;
    logic        clk, rst, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready;
    logic [15:0] awaddr, araddr, ratedPower, ix;
    logic [31:0] wdata, rdata, startFreq, rdv;
    logic [1:0]  bresp, rresp, rsp;
    smpb_param_t params;
    int          num_errors = 0, checked = 0;
    // code registers and their top values
    logic [15:0] cix [6] = '{IX_BMETH, IX_BVAL, IX_BKNEE, IX_CURVE, IX_RSW,
        IX_VGAIN};
    logic [15:0] cmx [6] = '{16'h1, 16'hc8, 16'h1f4, 16'h4, 16'h2, 16'hff};
    // capacity steps: index, data, answer, rated power after
    logic [15:0] kix [9] = '{IX_REGION, IX_CAP, IX_CAP, IX_REGION, IX_CAP,
        IX_CAP, IX_CAP, IX_REGION, IX_CAP};
    logic [15:0] kd [9] = '{16'h0, 16'h1, 16'h2, 16'h1, 16'h1, 16'h1a,
        16'h1b, 16'h2, 16'h9};
    logic [1:0]  kr [9] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0,
        2'h0};
    logic [15:0] kp [9] = '{16'h4b, 16'h4b, 16'h28, 16'h0, 16'h25, 16'h3e80,
        16'h3e80, 16'h3e80, 16'h172};
    logic [15:0] px [4] = '{IX_ACC1_HI, IX_DEC1_HI, IX_ACC2_HI, IX_DEC2_HI};

    smpb_bank dut_u (.ce(1'b1), .wstrb(4'hf), .*);
    smpb_host host_u (.*);

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic report_and_stop();
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // single word write and read with answer check
    task automatic w1(logic [15:0] i, logic [15:0] d, logic [1:0] e);
        host_u.wr(i, d, rsp);
        cmp("bresp", {30'h0, e}, {30'h0, rsp});
    endtask
    task automatic r1(logic [15:0] i, logic [15:0] e, logic [1:0] er);
        host_u.rd(i, rdv, rsp);
        cmp("rdata", {16'h0, e}, rdv);
        cmp("rresp", {30'h0, er}, {30'h0, rsp});
    endtask
    // split pairs, high word first
    task automatic w2(logic [15:0] i, logic [31:0] d, logic [1:0] e);
        w1(i, d[31:16], RESP_OKAY);
        w1(i + 16'h1, d[15:0], e);
    endtask
    task automatic r2(logic [15:0] i, logic [31:0] e);
        r1(i, e[31:16], RESP_OKAY);
        r1(i + 16'h1, e[15:0], RESP_OKAY);
    endtask

    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    // test sequence
    initial
    begin
        rst = 1'b1;
        startFreq = 32'h1f4;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (px[i])
        begin
            r2(px[i], 32'hbb8);
            w2(px[i], 32'h0005_7e40, RESP_OKAY);
            w2(px[i], 32'h0005_7e41, RESP_SLVERR);
            w2(px[i], 32'h0, RESP_SLVERR);
            r2(px[i], 32'h0005_7e40);
            w2(px[i], 32'h1, RESP_OKAY);
        end
        cmp("params", 32'h1, params.secondDecelTime);
        for (int i = 0; i < 4; i += 2)
        begin
            ix = IX_ATRN_HI + i[15:0];
            w2(ix, 32'h9c41, RESP_SLVERR);
            w2(ix, 32'h9c40, RESP_OKAY);
            r2(ix, 32'h9c40);
        end
        foreach (cix[i])
        begin
            for (int v = 0; v <= 4 && v <= cmx[i]; v++)
                w1(cix[i], v[15:0], RESP_OKAY);
            w1(cix[i], cmx[i] + 16'h1, RESP_SLVERR);
            w1(cix[i], cmx[i], RESP_OKAY);
            r1(cix[i], cmx[i], RESP_OKAY);
        end
        w1(IX_MAXF, 16'h191, RESP_SLVERR);
        w1(IX_MAXF, 16'h1d, RESP_SLVERR);
        w1(IX_MAXF, 16'h190, RESP_OKAY);
        w1(IX_BASE, 16'h190, RESP_OKAY);
        w1(IX_BASE, 16'h1d, RESP_SLVERR);
        w1(IX_MAXF, 16'h64, RESP_OKAY);
        w1(IX_BASE, 16'h65, RESP_SLVERR);
        r1(IX_BASE, 16'h190, RESP_OKAY);
        cmp("params", 32'h64, {16'h0, params.maximumFrequency});
        for (int i = 0; i < 2; i++)
        begin
            ix = i ? IX_LOL_HI : IX_MSPD_HI;
            w2(ix, 32'h0, RESP_OKAY);
            w2(ix, 32'h1f3, RESP_SLVERR);
            w2(ix, 32'h2711, RESP_SLVERR);
            w2(ix, 32'h2710, RESP_OKAY);
            r2(ix, 32'h2710);
        end
        w2(IX_LOL_HI, 32'h3e8, RESP_OKAY);
        w2(IX_UPL_HI, 32'h3e7, RESP_SLVERR);
        w2(IX_UPL_HI, 32'h2711, RESP_SLVERR);
        w2(IX_UPL_HI, 32'h3e8, RESP_OKAY);
        r2(IX_UPL_HI, 32'h3e8);
        cmp("params", 32'h3e8, params.upperFreqLimit);
        w1(16'h2107, 16'h1, RESP_SLVERR);
        r1(16'h2107, 16'h0, RESP_SLVERR);
        r1(16'h223f, 16'h0, RESP_SLVERR);
        foreach (kix[i])
        begin
            w1(kix[i], kd[i], kr[i]);
            repeat (2) @(posedge clk);
            cmp("ratedPower", {16'h0, kp[i]}, {16'h0, ratedPower});
        end
        r1(IX_RATED, 16'h172, RESP_OKAY);
        w1(IX_REGION, 16'h3, RESP_SLVERR);
        report_and_stop();
    end
endmodule // smpb_bank_tb_top
`default_nettype wire
